// ---- core_exec_pkg.sv ----
// Constants and operation codes for the instruction subset execution block
// Behaviour
// - Bit set skips next instruction, two cycles
// - Watchdog clear zeroes counter and prescaler
// - Watchdog clear sets timeout and powerdown flags
// - Call pushes PC plus one to stack
// - Call loads eleven-bit operand into PC low
// - Call takes PC bits 12:11 from latch
// - Call takes two instruction cycles, more if no next instruction is there to drop
// - Complement writes inverted register, updates zero
// - Destination 0 is accumulator, 1 register
// - Decrement writes register minus one, updates zero
// - Register clear writes zero, sets zero flag
// - Accumulator clear writes zero, sets zero flag
// - PC change or true test adds NOP
package core_exec_pkg;

    localparam int unsigned DATA_W       = 8;
    localparam int unsigned ADDR_W       = 7;
    localparam int unsigned PC_W         = 13;
    localparam int unsigned LIT_W        = 11;
    localparam int unsigned LATCH_W      = 5;
    localparam int unsigned PHASES       = 4;

    // Operation select on the instruction port
    localparam logic [2:0] skip_if_bit_set_op = 3'h0;
    localparam logic [2:0] watchdog_clear_op  = 3'h1;
    localparam logic [2:0] subroutine_call_op = 3'h2;
    localparam logic [2:0] complement_reg_op  = 3'h3;
    localparam logic [2:0] clear_reg_op       = 3'h4;
    localparam logic [2:0] decrement_reg_op   = 3'h5;
    localparam logic [2:0] clear_accum_op     = 3'h6;

    // APB register byte offsets
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] PC_LATCH_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS     = 8'h08;
    localparam logic [7:0] ACCUM_OFS      = 8'h0c;
    localparam logic [7:0] PC_OFS         = 8'h10;

    // Field positions
    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned ST_ZERO_BIT    = 0;
    localparam int unsigned ST_PD_BIT      = 3;
    localparam int unsigned ST_TO_BIT      = 4;
    localparam int unsigned LATCH_HI_BIT   = 4;
    localparam int unsigned LATCH_LO_BIT   = 3;

    // Values after reset
    localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
    localparam logic [DATA_W-1:0]  ACCUM_RST = 8'h00;
    localparam logic [LATCH_W-1:0] LATCH_RST = 5'h00;
    localparam logic               RUN_RST   = 1'b0;
    localparam logic               FLAG_RST  = 1'b1;

endpackage

// ---- cycle_phase_gen.sv ----
// Divider that splits the clock into instruction cycles of several phases
`timescale 1ns/1ps
`default_nettype none
module cycle_phase_gen #(
    parameter int unsigned PHASES = core_exec_pkg::PHASES
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // Phase enables
    output logic      o_start,
    output logic      o_last
);
    localparam int unsigned CW = (PHASES > 1) ? $clog2(PHASES) : 1;
    localparam logic [CW-1:0] LAST_PH = CW'(PHASES - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    always_comb
    begin
        cnt_d = (cnt_q == LAST_PH) ? '0 : cnt_q + CW'(1);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign o_start = (cnt_q == '0);
    assign o_last  = (cnt_q == LAST_PH);
endmodule // cycle_phase_gen
`default_nettype wire

// ---- core_exec.sv ----
// Execution unit for skip, watchdog clear, call, complement, clear and decrement
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module core_exec #(
    parameter int unsigned PHASES = core_exec_pkg::PHASES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // Instruction port
    input  wire logic        i_instr_valid,
    input  wire logic [2:0]  i_instr_op,
    input  wire logic [6:0]  i_instr_addr,
    input  wire logic [2:0]  i_instr_bit,
    input  wire logic        i_instr_dest,
    input  wire logic [10:0] i_instr_lit,
    output logic             o_instr_ack,
    output logic             o_instr_done,
    output logic             o_cycle_nop,
    // Register file
    input  wire logic [7:0]  i_reg_rdata,
    output logic [6:0]       o_reg_addr,
    output logic             o_reg_we,
    output logic [7:0]       o_reg_wdata,
    // Stack, watchdog and core state
    output logic             o_stack_push,
    output logic [12:0]      o_stack_data,
    output logic             o_watchdog_clear,
    output logic             o_prescaler_clear,
    output logic [12:0]      o_pc,
    output logic [7:0]       o_accum,
    output logic             o_zero_flag,
    output logic             o_timeout_flag,
    output logic             o_powerdown_flag,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr
);
    logic start;
    logic last;

    cycle_phase_gen #(.PHASES(PHASES)) i_cycle_phase_gen (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .o_start   (start),
        .o_last    (last)
    );

    function automatic logic to_register(input logic [2:0] op, input logic dest);
        to_register = (op == core_exec_pkg::clear_reg_op) ||
                      (((op == core_exec_pkg::complement_reg_op) ||
                        (op == core_exec_pkg::decrement_reg_op)) && dest);
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == core_exec_pkg::CTRL_OFS) || (a == core_exec_pkg::PC_LATCH_OFS) ||
                     (a == core_exec_pkg::STATUS_OFS) || (a == core_exec_pkg::ACCUM_OFS) ||
                     (a == core_exec_pkg::PC_OFS);
    endfunction

    // Execution state
    logic        busy_q,      busy_d;
    logic [2:0]  op_q,        op_d;
    logic [6:0]  addr_q,      addr_d;
    logic [2:0]  bit_q,       bit_d;
    logic        dest_q,      dest_d;
    logic [10:0] lit_q,       lit_d;
    logic        nop_q,       nop_d;
    logic        nop_skip_q,  nop_skip_d;
    logic        drop_q,      drop_d;
    logic [12:0] pc_q,        pc_d;
    logic [7:0]  accum_q,     accum_d;
    logic        zero_q,      zero_d;
    logic        to_q,        to_d;
    logic        pd_q,        pd_d;
    logic        we_q,        we_d;
    logic [7:0]  wdata_q,     wdata_d;
    logic        push_q,      push_d;
    logic [12:0] sdata_q,     sdata_d;
    logic        wdt_q,       wdt_d;
    logic        presc_q,     presc_d;
    logic        ack_q,       ack_d;
    logic        done_q,      done_d;
    // Software registers
    logic        run_q,       run_d;
    logic [4:0]  latch_q,     latch_d;
    logic        pready_q,    pready_d;
    logic [31:0] prdata_q,    prdata_d;
    logic        pslverr_q,   pslverr_d;

    logic       exec;
    logic [7:0] result;
    logic       wr_st;
    logic       apb_wr;

    assign exec   = last && busy_q;
    assign apb_wr = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
    assign wr_st  = apb_wr && (i_paddr == core_exec_pkg::STATUS_OFS);

    always_comb
    begin
        busy_d     = busy_q;
        op_d       = op_q;
        addr_d     = addr_q;
        bit_d      = bit_q;
        dest_d     = dest_q;
        lit_d      = lit_q;
        nop_d      = nop_q;
        nop_skip_d = nop_skip_q;
        drop_d     = drop_q;
        pc_d       = pc_q;
        accum_d    = accum_q;
        zero_d     = zero_q;
        to_d       = to_q;
        pd_d       = pd_q;
        we_d       = 1'b0;
        wdata_d    = wdata_q;
        push_d     = 1'b0;
        sdata_d    = sdata_q;
        wdt_d      = 1'b0;
        presc_d    = 1'b0;
        ack_d      = 1'b0;
        done_d     = 1'b0;
        result     = 8'h00;

        // Flags are write-one-to-clear; a same-cycle set below wins
        if (wr_st && i_pwdata[core_exec_pkg::ST_TO_BIT])
            to_d = 1'b0;
        if (wr_st && i_pwdata[core_exec_pkg::ST_PD_BIT])
            pd_d = 1'b0;

        // A discarded instruction is still acked so the fetcher moves on
        if (start && i_instr_valid && !busy_q && !ack_q && (nop_q || run_q))
        begin
            ack_d = 1'b1;
            if (!nop_q)
            begin
                busy_d = 1'b1;
                op_d   = i_instr_op;
                addr_d = i_instr_addr;
                bit_d  = i_instr_bit;
                dest_d = i_instr_dest;
                lit_d  = i_instr_lit;
            end
            else
                drop_d = 1'b1;
        end

        // The forced no-op lasts until a following instruction has really been dropped,
        // so a slow fetcher cannot slip the skipped instruction past it
        if (last && nop_q && drop_q)
        begin
            nop_d  = 1'b0;
            drop_d = 1'b0;
            done_d = 1'b1;
            if (nop_skip_q)
                pc_d = pc_q + 13'h0001;
        end

        if (exec)
        begin
            busy_d = 1'b0;
            done_d = 1'b1;
            pc_d   = pc_q + 13'h0001;
            case (op_q)
                core_exec_pkg::skip_if_bit_set_op:
                begin
                    if (i_reg_rdata[bit_q])
                    begin
                        nop_d      = 1'b1;
                        nop_skip_d = 1'b1;
                    end
                end
                core_exec_pkg::watchdog_clear_op:
                begin
                    wdt_d   = 1'b1;
                    presc_d = 1'b1;
                    to_d    = 1'b1;
                    pd_d    = 1'b1;
                end
                core_exec_pkg::subroutine_call_op:
                begin
                    push_d     = 1'b1;
                    sdata_d    = pc_q + 13'h0001;
                    pc_d       = {latch_q[core_exec_pkg::LATCH_HI_BIT:core_exec_pkg::LATCH_LO_BIT],
                                  lit_q};
                    nop_d      = 1'b1;
                    nop_skip_d = 1'b0;
                end
                core_exec_pkg::complement_reg_op:
                begin
                    result = ~i_reg_rdata;
                    zero_d = (result == 8'h00);
                end
                core_exec_pkg::decrement_reg_op:
                begin
                    result = i_reg_rdata - 8'h01;
                    zero_d = (result == 8'h00);
                end
                core_exec_pkg::clear_reg_op:
                begin
                    result = 8'h00;
                    zero_d = 1'b1;
                end
                core_exec_pkg::clear_accum_op:
                begin
                    result = 8'h00;
                    zero_d = 1'b1;
                    accum_d = 8'h00;
                end
                default:
                begin
                    result = 8'h00;
                end
            endcase
            if (to_register(op_q, dest_q))
            begin
                we_d    = 1'b1;
                wdata_d = result;
            end
            else if ((op_q == core_exec_pkg::complement_reg_op) || (op_q == core_exec_pkg::decrement_reg_op))
                accum_d = result;
        end
    end

    // APB slave: one wait state, answer registered
    always_comb
    begin
        run_d     = run_q;
        latch_d   = latch_q;
        pready_d  = 1'b0;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (i_psel && i_penable && !pready_q)
        begin
            pready_d  = 1'b1;
            pslverr_d = !reg_mapped(i_paddr);
            prdata_d  = 32'h0000_0000;
            if (!i_pwrite)
            begin
                case (i_paddr)
                    core_exec_pkg::CTRL_OFS:     prdata_d[core_exec_pkg::CTRL_RUN_BIT] = run_q;
                    core_exec_pkg::PC_LATCH_OFS: prdata_d[4:0] = latch_q;
                    core_exec_pkg::STATUS_OFS:
                    begin
                        prdata_d[core_exec_pkg::ST_ZERO_BIT] = zero_q;
                        prdata_d[core_exec_pkg::ST_PD_BIT]   = pd_q;
                        prdata_d[core_exec_pkg::ST_TO_BIT]   = to_q;
                    end
                    core_exec_pkg::ACCUM_OFS:    prdata_d[7:0] = accum_q;
                    core_exec_pkg::PC_OFS:       prdata_d[12:0] = pc_q;
                    default:                     prdata_d = 32'h0000_0000;
                endcase
            end
        end
        if (apb_wr && (i_paddr == core_exec_pkg::CTRL_OFS))
            run_d = i_pwdata[core_exec_pkg::CTRL_RUN_BIT];
        if (apb_wr && (i_paddr == core_exec_pkg::PC_LATCH_OFS))
            latch_d = i_pwdata[4:0];
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            busy_q     <= 1'b0;
            op_q       <= 3'h0;
            addr_q     <= 7'h00;
            bit_q      <= 3'h0;
            dest_q     <= 1'b0;
            lit_q      <= 11'h000;
            nop_q      <= 1'b0;
            nop_skip_q <= 1'b0;
            drop_q     <= 1'b0;
            pc_q       <= core_exec_pkg::PC_RST;
            accum_q    <= core_exec_pkg::ACCUM_RST;
            zero_q     <= 1'b0;
            to_q       <= core_exec_pkg::FLAG_RST;
            pd_q       <= core_exec_pkg::FLAG_RST;
            we_q       <= 1'b0;
            wdata_q    <= 8'h00;
            push_q     <= 1'b0;
            sdata_q    <= 13'h0000;
            wdt_q      <= 1'b0;
            presc_q    <= 1'b0;
            ack_q      <= 1'b0;
            done_q     <= 1'b0;
            run_q      <= core_exec_pkg::RUN_RST;
            latch_q    <= core_exec_pkg::LATCH_RST;
            pready_q   <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            pslverr_q  <= 1'b0;
        end
        else
        begin
            busy_q     <= busy_d;
            op_q       <= op_d;
            addr_q     <= addr_d;
            bit_q      <= bit_d;
            dest_q     <= dest_d;
            lit_q      <= lit_d;
            nop_q      <= nop_d;
            nop_skip_q <= nop_skip_d;
            drop_q     <= drop_d;
            pc_q       <= pc_d;
            accum_q    <= accum_d;
            zero_q     <= zero_d;
            to_q       <= to_d;
            pd_q       <= pd_d;
            we_q       <= we_d;
            wdata_q    <= wdata_d;
            push_q     <= push_d;
            sdata_q    <= sdata_d;
            wdt_q      <= wdt_d;
            presc_q    <= presc_d;
            ack_q      <= ack_d;
            done_q     <= done_d;
            run_q      <= run_d;
            latch_q    <= latch_d;
            pready_q   <= pready_d;
            prdata_q   <= prdata_d;
            pslverr_q  <= pslverr_d;
        end
    end

    assign o_instr_ack       = ack_q;
    assign o_instr_done      = done_q;
    assign o_cycle_nop       = nop_q;
    assign o_reg_addr        = addr_q;
    assign o_reg_we          = we_q;
    assign o_reg_wdata       = wdata_q;
    assign o_stack_push      = push_q;
    assign o_stack_data      = sdata_q;
    assign o_watchdog_clear  = wdt_q;
    assign o_prescaler_clear = presc_q;
    assign o_pc              = pc_q;
    assign o_accum           = accum_q;
    assign o_zero_flag       = zero_q;
    assign o_timeout_flag    = to_q;
    assign o_powerdown_flag  = pd_q;
    assign o_pready          = pready_q;
    assign o_prdata          = prdata_q;
    assign o_pslverr         = pslverr_q;

    property p_skip_set;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::skip_if_bit_set_op && i_reg_rdata[bit_q] |=> nop_q && nop_skip_q;
    endproperty
    a_skip_set: assert property (p_skip_set) else $error("skip with bit set gave no nop");

    property p_skip_clear;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::skip_if_bit_set_op && !i_reg_rdata[bit_q] |=> !nop_q;
    endproperty
    a_skip_clear: assert property (p_skip_clear) else $error("skip with bit clear inserted nop");

    property p_wdt_clear;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::watchdog_clear_op |=> o_watchdog_clear && o_prescaler_clear ##1 !o_watchdog_clear;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear pulse wrong");

    property p_wdt_flags;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::watchdog_clear_op |=> o_timeout_flag && o_powerdown_flag;
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("status flags not set");

    property p_call_push;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::subroutine_call_op |=> o_stack_push && o_stack_data == $past(pc_q) + 13'h0001;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call pushed wrong address");

    property p_call_pc;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::subroutine_call_op |=>
            o_pc[10:0] == $past(lit_q) && o_pc[12:11] == $past(latch_q[4:3]);
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call target wrong");

    property p_call_two;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::subroutine_call_op |=> nop_q && !busy_q ##1 nop_q && !busy_q;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call not followed by nop");

    property p_comp_reg;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::complement_reg_op && dest_q |=>
            o_reg_we && o_reg_wdata == ~$past(i_reg_rdata) && !nop_q;
    endproperty
    a_comp_reg: assert property (p_comp_reg) else $error("complement result wrong");

    property p_dest_accum;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && (op_q == core_exec_pkg::complement_reg_op || op_q == core_exec_pkg::decrement_reg_op) && !dest_q
            |=> !o_reg_we;
    endproperty
    a_dest_accum: assert property (p_dest_accum) else $error("register written for accumulator dest");

    property p_dec;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::decrement_reg_op && !dest_q |=>
            o_accum == 8'($past(i_reg_rdata) - 8'h01) && o_zero_flag == ($past(i_reg_rdata) == 8'h01);
    endproperty
    a_dec: assert property (p_dec) else $error("decrement result or zero wrong");

    property p_clr_reg;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::clear_reg_op |=> o_reg_we && o_reg_wdata == 8'h00 && o_zero_flag;
    endproperty
    a_clr_reg: assert property (p_clr_reg) else $error("register clear wrong");

    property p_clr_accum;
        @(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::clear_accum_op |=> o_accum == 8'h00 && o_zero_flag && !o_reg_we;
    endproperty
    a_clr_accum: assert property (p_clr_accum) else $error("accumulator clear wrong");

    c_skip: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::skip_if_bit_set_op ##1 nop_q);
    c_call: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::subroutine_call_op);
    c_dec_zero: cover property (@(posedge i_clk) disable iff (i_sys_rst)
        exec && op_q == core_exec_pkg::decrement_reg_op && i_reg_rdata == 8'h01);
endmodule // core_exec
`default_nettype wire

// ---- tb_core_exec.sv ----
// Self-checking testbench for the instruction subset execution block
`timescale 1ns/1ps
`default_nettype none
module tb_core_exec;
    logic        i_clk, i_sys_rst, i_instr_valid, i_instr_dest, i_psel, i_penable, i_pwrite;
    logic [2:0]  i_instr_op, i_instr_bit;
    logic [6:0]  i_instr_addr, o_reg_addr;
    logic [10:0] i_instr_lit;
    logic [7:0]  i_reg_rdata, i_paddr, o_reg_wdata, o_accum;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic        o_instr_ack, o_instr_done, o_cycle_nop, o_reg_we, o_stack_push, o_watchdog_clear;
    logic        o_prescaler_clear, o_zero_flag, o_timeout_flag, o_powerdown_flag, o_pready, o_pslverr, err;
    logic [12:0] o_stack_data, o_pc, pc;
    int          error_cnt, n_tests;

    core_exec i_core_exec (.*);

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel    <= 1'b1;
        i_pwrite  <= wr;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        repeat (20)
        begin
            @(posedge i_clk);
            if (o_pready === 1'b1)
                break;
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // One instruction: offer, wait for ack, withdraw, wait for the cycle end
    task automatic step(input logic [2:0] op, input logic [6:0] a, input logic [2:0] b, input logic dst,
                        input logic [10:0] lit, input logic [7:0] rdat);
        @(posedge i_clk);
        i_instr_valid <= 1'b1;
        i_instr_op    <= op;
        i_instr_addr  <= a;
        i_instr_bit   <= b;
        i_instr_dest  <= dst;
        i_instr_lit   <= lit;
        i_reg_rdata   <= rdat;
        repeat (20)
        begin
            @(negedge i_clk);
            if (o_instr_ack === 1'b1)
                break;
        end
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
        repeat (20)
        begin
            @(negedge i_clk);
            if (o_instr_done === 1'b1)
                break;
        end
        pc = pc + 13'h0001;
    endtask

    task automatic res(input logic we, input logic [7:0] wd, input logic [7:0] ac, input logic z);
        chk(32'(o_reg_we), 32'(we));
        if (we)
            chk(32'(o_reg_wdata), 32'(wd));
        chk(32'(o_accum), 32'(ac));
        chk(32'(o_zero_flag), 32'(z));
        chk(32'(o_pc), 32'(pc));
    endtask

    initial
    begin
        #20000;
        error_cnt++;
        complete_run();
    end

    initial
    begin
        {i_instr_valid, i_instr_dest, i_psel, i_penable, i_pwrite} = 5'h00;
        {i_instr_op, i_instr_bit, i_instr_addr, i_instr_lit} = 24'h000000;
        {i_reg_rdata, i_paddr, i_pwdata} = 48'h000000000000;
        error_cnt = 0;
        n_tests = 0;
        pc = 13'h0000;
        i_sys_rst = 1'b1;
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        apb(1'b1, core_exec_pkg::CTRL_OFS, 32'h00000001);
        // Low latch bits set too, so the call must ignore them
        apb(1'b1, core_exec_pkg::PC_LATCH_OFS, 32'h00000017);
        apb(1'b1, core_exec_pkg::STATUS_OFS, 32'h00000018);
        apb(1'b0, 8'h20, 32'h00000000);
        chk(32'(err), 32'h1);
        chk(32'({o_timeout_flag, o_powerdown_flag}), 32'h0);
        step(core_exec_pkg::watchdog_clear_op, 7'h00, 3'h0, 1'b0, 11'h000, 8'h00);
        chk(32'({o_watchdog_clear, o_prescaler_clear}), 32'h3);
        chk(32'({o_timeout_flag, o_powerdown_flag}), 32'h3);
        step(core_exec_pkg::complement_reg_op, 7'h7f, 3'h0, 1'b1, 11'h000, 8'hff);
        chk(32'(o_reg_addr), 32'h7f);
        res(1'b1, 8'h00, 8'h00, 1'b1);
        step(core_exec_pkg::complement_reg_op, 7'h01, 3'h0, 1'b0, 11'h000, 8'h5a);
        res(1'b0, 8'h00, 8'ha5, 1'b0);
        step(core_exec_pkg::decrement_reg_op, 7'h02, 3'h0, 1'b1, 11'h000, 8'h01);
        res(1'b1, 8'h00, 8'ha5, 1'b1);
        step(core_exec_pkg::decrement_reg_op, 7'h03, 3'h0, 1'b0, 11'h000, 8'h00);
        res(1'b0, 8'h00, 8'hff, 1'b0);
        step(core_exec_pkg::clear_reg_op, 7'h04, 3'h0, 1'b0, 11'h000, 8'h77);
        res(1'b1, 8'h00, 8'hff, 1'b1);
        step(core_exec_pkg::complement_reg_op, 7'h05, 3'h0, 1'b0, 11'h000, 8'h00);
        step(core_exec_pkg::clear_accum_op, 7'h00, 3'h0, 1'b0, 11'h000, 8'h00);
        res(1'b0, 8'h00, 8'h00, 1'b1);
        step(core_exec_pkg::complement_reg_op, 7'h06, 3'h0, 1'b0, 11'h000, 8'h80);
        step(core_exec_pkg::skip_if_bit_set_op, 7'h07, 3'h7, 1'b0, 11'h000, 8'h7f);
        chk(32'(o_cycle_nop), 32'h0);
        step(core_exec_pkg::skip_if_bit_set_op, 7'h07, 3'h7, 1'b0, 11'h000, 8'h80);
        chk(32'(o_cycle_nop), 32'h1);
        // The offered clear must be swallowed by the forced no-op cycle
        step(core_exec_pkg::clear_accum_op, 7'h00, 3'h0, 1'b0, 11'h000, 8'h00);
        res(1'b0, 8'h00, 8'h7f, 1'b0);
        step(core_exec_pkg::subroutine_call_op, 7'h00, 3'h0, 1'b0, 11'h555, 8'h00);
        chk(32'(o_stack_push), 32'h1);
        chk(32'(o_stack_data), 32'(pc));
        chk(32'(o_pc), 32'h1555);
        chk(32'(o_cycle_nop), 32'h1);
        step(core_exec_pkg::clear_accum_op, 7'h00, 3'h0, 1'b0, 11'h000, 8'h00);
        chk(32'(o_accum), 32'h7f);
        complete_run();
    end
endmodule // tb_core_exec
`default_nettype wire
